/* File: bench/sdbm_bus_model.sv */
// arbiter and byte memory on the far side of the dma master
`timescale 1ns/10ps
module sdbm_bus_model (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // from the master
    input  wire logic        bus_request_i,
    input  wire logic        master_oe_i,
    input  wire logic        addr_latch_strobe_n_i,
    input  wire logic        data_strobe_n_i,
    input  wire logic [15:0] ad_i,
    input  wire logic [2:0]  wait_cyc_i,
    // to the master
    output logic             bus_grant_o,
    output wire logic        ready_n_o,
    output wire logic [15:0] ad_o
);
    logic [7:0]  lat_q;
    logic [2:0]  cnt_q;
    logic [15:0] last_q;
    // grant follows request one clock later and goes with it
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            bus_grant_o <= 1'b0;
            lat_q <= 8'h00;
            cnt_q <= 3'h0;
            last_q <= 16'h0000;
        end else begin
            bus_grant_o <= bus_request_i;
            if (!addr_latch_strobe_n_i && master_oe_i)
                lat_q <= ad_i[7:0];
            cnt_q <= data_strobe_n_i ? 3'h0 : cnt_q + {2'h0, cnt_q != 3'h7};
            last_q <= ad_o;
        end
    end
    // ready is clock-aligned here; pulled high outside the data strobe
    assign ready_n_o = !(!data_strobe_n_i && cnt_q >= wait_cyc_i);
    // released bus toggles so a stale byte cannot pass for data
    assign ad_o = !data_strobe_n_i ? {8'h00, lat_q + 8'h11} : ~last_q;
endmodule

/* File: bench/sdbm_chk.sv */
// port-level assertions for the serial dma bus master
`timescale 1ns/10ps
module sdbm_chk (
    // clock, reset and apb
    input wire logic        sys_clk_i, rst_i, psel_i, penable_i, pready_o, pslverr_o,
    // bus mastering
    input wire logic        bus_request_out_o, bus_grant_in_i, master_oe_o, ad_oe_o,
    input wire logic        upper_addr_strobe_o, addr_latch_strobe_n_o, data_strobe_n_o,
    input wire logic [15:0] ad_o,
    // host acknowledge
    input wire logic        irq_acknowledge_n_i
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // setup states, then a quiet turnaround and three data strobe states
    sequence s_addr;
        upper_addr_strobe_o ##1 !addr_latch_strobe_n_o;
    endsequence
    sequence s_data;
        data_strobe_n_o && addr_latch_strobe_n_o ##1 !data_strobe_n_o [*3];
    endsequence
    a_setup_then_data: assert property (upper_addr_strobe_o |-> s_addr ##1 s_data)
        else $error("dma cycle states out of order");
    a_uas_first: assert property ($rose(master_oe_o) |-> upper_addr_strobe_o)
        else $error("dma cycle without upper address strobe");
    a_req_first: assert property ($rose(master_oe_o) |-> bus_request_out_o)
        else $error("mastering without request");
    // synchronised grant: the bus is taken four clocks after the pin at the earliest
    a_grant_before_drive: assert property (master_oe_o |->
        $past(bus_grant_in_i, 4) || $past(bus_grant_in_i, 5))
        else $error("bus driven without grant");
    a_float_after_drop: assert property (!bus_grant_in_i [*6] |-> !master_oe_o)
        else $error("master outputs kept after grant loss");
    a_vec_halves: assert property (ad_oe_o && !master_oe_o |-> ad_o[15:8] == ad_o[7:0])
        else $error("vector not on both bus halves");
    a_vec_on_ack: assert property (ad_oe_o && !master_oe_o |->
        !$past(irq_acknowledge_n_i, 3) || !$past(irq_acknowledge_n_i, 4))
        else $error("vector driven outside acknowledge");
    a_pready_once: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("apb answer not a single cycle");
    a_err_with_ready: assert property (pslverr_o |-> pready_o)
        else $error("slave error without ready");
endmodule
bind sdbm_top sdbm_chk u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .bus_request_out_o(bus_request_out_o), .bus_grant_in_i(bus_grant_in_i),
    .master_oe_o(master_oe_o), .ad_oe_o(ad_oe_o), .upper_addr_strobe_o(upper_addr_strobe_o),
    .addr_latch_strobe_n_o(addr_latch_strobe_n_o), .data_strobe_n_o(data_strobe_n_o),
    .ad_o(ad_o), .irq_acknowledge_n_i(irq_acknowledge_n_i));

/* File: bench/sdbm_top_test.sv */
// self-checking bench for the serial dma bus master
`timescale 1ns/10ps
`include "sdbm_consts.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module sdbm_top_test;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, perv;
    logic [7:0] pa = 8'h00, txd;
    logic [31:0] pwd = 32'h0, prd, rdv;
    logic prdy, perr, req, gnt, rdy_n, ad_oe, uas, as_n, ds_n, rnw, moe, sclr, txv, irq;
    logic has_n = 1, ack_n = 1, acc_n = 1, sirq = 0;
    logic [15:0] ad_i, ad_o, vlast;
    logic [2:0] wt = 3'h0;
    logic [7:0] txq[$];
    int error_cnt = 0, comparisons = 0, nclr = 0, nvec = 0, i;
    always #2.5 clk = ~clk;
    sdbm_top i_dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
        .pslverr_o(perr), .bus_request_out_o(req), .bus_grant_in_i(gnt), .ready_n_i(rdy_n),
        .ad_i(ad_i), .ad_o(ad_o), .ad_oe_o(ad_oe), .upper_addr_strobe_o(uas),
        .addr_latch_strobe_n_o(as_n), .data_strobe_n_o(ds_n), .read_not_write_o(rnw),
        .master_oe_o(moe), .addr_latch_strobe_n_i(has_n), .irq_acknowledge_n_i(ack_n),
        .access_strobe_n_i(acc_n), .serial_irq_i(sirq), .serial_irq_clr_o(sclr),
        .tx_data_o(txd), .tx_valid_o(txv), .irq_o(irq));
    sdbm_bus_model i_mem (.sys_clk_i(clk), .rst_i(rst), .bus_request_i(req),
        .master_oe_i(moe), .addr_latch_strobe_n_i(as_n), .data_strobe_n_i(ds_n),
        .ad_i(ad_o), .wait_cyc_i(wt), .bus_grant_o(gnt), .ready_n_o(rdy_n), .ad_o(ad_i));
    // collect bytes, clear pulses and vector drives
    always @(posedge clk) begin
        if (txv === 1'b1) txq.push_back(txd);
        if (sclr === 1'b1) nclr++;
        if (ad_oe === 1'b1 && moe === 1'b0) begin nvec++; vlast = ad_o; end
    end
    // one apb transfer; waits for pready, never a fixed count
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        begin
            @(posedge clk); psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
            @(posedge clk); pen <= 1;
            @(posedge clk); n = 0;
            while (prdy !== 1'b1 && n < 50) begin @(posedge clk); n++; end
            if (n == 50) error_cnt++;
            rdv = prd; perv = perr; psel <= 0; pen <= 0;
        end
    endtask
    // host strobe pulse: 0 address strobe, 1 acknowledge, 2 access
    task pulse(input int k, input int lo, input int hi);
        begin
            @(posedge clk);
            case (k) 0: has_n <= 0; 1: ack_n <= 0; default: acc_n <= 0; endcase
            repeat (lo) @(posedge clk);
            case (k) 0: has_n <= 1; 1: ack_n <= 1; default: acc_n <= 1; endcase
            repeat (hi) @(posedge clk);
        end
    endtask
    task final_report;
        begin
            if (error_cnt == 0 && comparisons > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // watchdog well beyond the expected run
    initial begin #200000; error_cnt++; final_report; end
    initial begin
        repeat (2) @(posedge clk); rst <= 0;
        apb(0, `SDBM_OFF_MIC, 0); `CHK("mic reset", `SDBM_MIC_RST, rdv[7:0])
        apb(0, `SDBM_OFF_VECA, 0); `CHK("veca reset", `SDBM_VEC_RST, rdv[7:0])
        apb(1, 8'h2C, 32'hFFFF); `CHK("unmapped err", 1'b1, perv)
        apb(0, 8'h2C, 0); `CHK("unmapped data", 32'h0, rdv)
        // software acknowledge: channel b vector shows the serial source
        apb(1, `SDBM_OFF_MIC, 1 << `SDBM_MIC_SOFTACK); apb(1, `SDBM_OFF_VECA, 32'hA0);
        sirq <= 1; repeat (4) @(posedge clk);
        apb(0, `SDBM_OFF_VECB, 0); `CHK("vecb", 8'hA6, rdv[7:0])
        sirq <= 0; repeat (3) @(posedge clk); `CHK("serial clear", 1, nclr)
        apb(0, `SDBM_OFF_VECA, 0); `CHK("veca kept", 8'hA0, rdv[7:0])
        // mux mode: serial status waits for an address strobe
        apb(1, `SDBM_OFF_ISTAT, 32'hF); apb(1, `SDBM_OFF_IMASK, 1 << `SDBM_EV_SERIAL);
        apb(1, `SDBM_OFF_MIC, 1 << `SDBM_MIC_MUX); sirq <= 1; repeat (8) @(posedge clk);
        `CHK("irq before strobe", 1'b0, irq)
        pulse(0, 2, 6); `CHK("irq after strobe", 1'b1, irq)
        sirq <= 0; pulse(0, 2, 2); apb(1, `SDBM_OFF_ISTAT, 32'hF);
        apb(1, `SDBM_OFF_IMASK, 0); repeat (3) @(posedge clk); `CHK("irq cleared", 1'b0, irq)
        // double pulse acknowledge: first pulse ignored
        apb(1, `SDBM_OFF_MIC, 1 << `SDBM_MIC_DBLPULSE); nvec = 0;
        pulse(1, 4, 6); `CHK("first ack silent", 0, nvec)
        pulse(1, 4, 6); `CHK("second ack drives", 1'b1, nvec > 0)
        `CHK("vector halves", 16'hA0A0, vlast)
        // channel 0 by enable register, read-modify-write, prompt memory
        apb(1, `SDBM_OFF_MIC, 0); apb(1, `SDBM_OFF_ADDR, 32'h0001_2340);
        apb(1, `SDBM_OFF_COUNT, 2); apb(1, `SDBM_OFF_IMASK, 1 << `SDBM_EV_TC0);
        apb(0, `SDBM_OFF_DMAEN, 0); apb(1, `SDBM_OFF_DMAEN, rdv | 1);
        for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge clk);
        `CHK("tc0 irq", 1'b1, irq)
        `CHK("request dropped", 1'b0, req)
        `CHK("dma reads", 1'b1, rnw)
        `CHK("bytes", 2, txq.size())
        `CHK("byte 0", 8'h51, txq[0])
        `CHK("byte 1", 8'h52, txq[1])
        apb(0, `SDBM_OFF_DMAIRQ, 0); `CHK("pending", 1'b1, rdv[0])
        apb(0, `SDBM_OFF_TCSTAT, 0); `CHK("tc set", 1'b1, rdv[0])
        apb(0, `SDBM_OFF_TCSTAT, 0); `CHK("tc read clear", 1'b0, rdv[0])
        apb(1, `SDBM_OFF_ISTAT, 32'hF); repeat (3) @(posedge clk); `CHK("w1c", 1'b0, irq)
        // channel b transmit by command code, slow memory, tc1 masked
        apb(0, `SDBM_OFF_DMAEN, 0); apb(1, `SDBM_OFF_DMAEN, rdv & 32'hFFFF_FFFE);
        wt <= 3'h3; apb(1, `SDBM_OFF_ADDR, 32'h0000_0080); apb(1, `SDBM_OFF_COUNT, 1);
        apb(1, `SDBM_OFF_CMD, {24'h0, `SDBM_CMD_ENB_TXB, 5'h00});
        apb(0, `SDBM_OFF_DMAEN, 0); `CHK("cmd enable", 1'b1, rdv[`SDBM_CH_TXB])
        for (i = 0; i < 400 && txq.size() < 3; i++) @(posedge clk);
        `CHK("slow byte", 8'h91, txq[2])
        repeat (20) @(posedge clk); `CHK("masked irq", 1'b0, irq)
        apb(1, `SDBM_OFF_ISTAT, 32'hF); apb(0, `SDBM_OFF_TCSTAT, 0);
        // strobe recovery: four clocks unaligned, chip select plays no part
        apb(1, `SDBM_OFF_IMASK, 1 << `SDBM_EV_RECOV);
        pulse(2, 1, 8); pulse(2, 1, 8);
        apb(0, `SDBM_OFF_ISTAT, 0); `CHK("long gap", 1'b0, rdv[`SDBM_EV_RECOV])
        pulse(2, 1, 1); pulse(2, 1, 4);
        apb(0, `SDBM_OFF_ISTAT, 0); `CHK("short gap", 1'b1, rdv[`SDBM_EV_RECOV])
        `CHK("recovery irq", 1'b1, irq)
        apb(1, `SDBM_OFF_ISTAT, 1 << `SDBM_EV_RECOV); repeat (3) @(posedge clk);
        `CHK("recovery clear", 1'b0, irq)
        final_report;
    end
endmodule

/* File: logic/sdbm_consts.vh */
// register offsets, field positions, reset values and timing counts for the dma bus master
`ifndef SDBM_CONSTS_VH
`define SDBM_CONSTS_VH
// register byte offsets
`define SDBM_OFF_MIC      8'h00
`define SDBM_OFF_CMD      8'h04
`define SDBM_OFF_DMAEN    8'h08
`define SDBM_OFF_TCSTAT   8'h0C
`define SDBM_OFF_ADDR     8'h10
`define SDBM_OFF_COUNT    8'h14
`define SDBM_OFF_VECA     8'h18
`define SDBM_OFF_VECB     8'h1C
`define SDBM_OFF_ISTAT    8'h20
`define SDBM_OFF_IMASK    8'h24
`define SDBM_OFF_DMAIRQ   8'h28
// master_irq_control fields
`define SDBM_MIC_ALIGNED  2
`define SDBM_MIC_MUX      3
`define SDBM_MIC_DBLPULSE 4
`define SDBM_MIC_SOFTACK  5
// channel command field and code
`define SDBM_CMD_HI       7
`define SDBM_CMD_LO       5
`define SDBM_CMD_ENB_TXB  3'h4
`define SDBM_CH_TXB       1
// interrupt status bits
`define SDBM_EV_TC0       0
`define SDBM_EV_TC1       1
`define SDBM_EV_RECOV     2
`define SDBM_EV_SERIAL    3
// vector source codes
`define SDBM_SRC_NONE     3'h0
`define SDBM_SRC_DMA0     3'h1
`define SDBM_SRC_DMA1     3'h2
`define SDBM_SRC_SERIAL   3'h3
// reset values
`define SDBM_MIC_RST      8'h00
`define SDBM_VEC_RST      8'h00
// strobe recovery in clocks
`define SDBM_RECOV_ALIGN  3'h3
`define SDBM_RECOV_OTHER  3'h4
`endif

/* File: logic/sdbm_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sdbm_sync #(
    parameter W = 5
) (
    input  wire         sys_clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] rst_val_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta_q;

    // first stage feeds only the second stage; both reset to the pin's idle
    // level so that no false edge shows up right after reset
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_q <= rst_val_i;
            q_o    <= rst_val_i;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

/* File: logic/sdbm_top.v */
// serial dma bus master: apb registers, bus mastering, interrupt acknowledge
`timescale 1ns/10ps
`include "sdbm_consts.vh"
// Summary of operation
// - raise bus request for dma; wait for grant before mastering
// - address and data lines stay undriven until grant is seen; the interrupt vector is driven without grant
// - interrupt vector drives both bus halves, never one alone
// - terminal count bits clear when their register is read
// - soft ack: channel b vector read reflects source, clears serial irq
// - dma irq state in pending and under-service bits, with tc0/tc1 events also in interrupt status
// - mux mode: serial irq status updates only on address strobe
// - every dma cycle has the upper address strobe phase
// - one transfer: two setup states then six transfer states
// - strobe recovery applies to every access, chip select or not
// - command code 100 in bits 7..5 enables and starts channel b tx
// - setting a dma enable bit enables and starts that channel
// - device samples ready and grant itself with synchronisers
// - double pulse ack: ignore first pulse, vector on second
module sdbm_top (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // bus arbitration
    output reg         bus_request_out_o,
    input  wire        bus_grant_in_i,
    input  wire        ready_n_i,
    // address/data bus
    input  wire [15:0] ad_i,
    output reg  [15:0] ad_o,
    output reg         ad_oe_o,
    // master control strobes
    output reg         upper_addr_strobe_o,
    output reg         addr_latch_strobe_n_o,
    output reg         data_strobe_n_o,
    output reg         read_not_write_o,
    output reg         master_oe_o,
    // host strobes seen as slave
    input  wire        addr_latch_strobe_n_i,
    input  wire        irq_acknowledge_n_i,
    input  wire        access_strobe_n_i,
    // serial core side
    input  wire        serial_irq_i,
    output reg         serial_irq_clr_o,
    output reg  [7:0]  tx_data_o,
    output reg         tx_valid_o,
    // interrupt
    output reg         irq_o
);
    // register state
    reg  [7:0]  mic_q;
    reg  [1:0]  en_q;
    reg  [1:0]  tc_q;
    reg  [31:0] addr_q;
    reg  [15:0] cnt_q;
    reg  [7:0]  veca_q;
    reg  [3:0]  istat_q;
    reg  [3:0]  imask_q;
    reg  [1:0]  ip_q;
    reg  [1:0]  ius_q;
    reg         ser_q;
    // pin edges and counters
    reg  [4:0]  pin_prev_q;
    reg         ack_first_q;
    reg         vec_drive_q;
    reg  [7:0]  vec_q;
    reg  [2:0]  gap_q;
    reg         gap_arm_q;
    wire [4:0]  pins_s;
    wire [8:0]  st;
    wire        xfer_done;

    // grant, ready, strobe, ack and address strobe all come from pins
    sdbm_sync #(.W(5)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .rst_val_i (5'h0F),
        .d_i       ({bus_grant_in_i, ready_n_i, access_strobe_n_i,
                     irq_acknowledge_n_i, addr_latch_strobe_n_i}),
        .q_o       (pins_s)
    );

    // pins keep their own polarity; only ready is turned active high here
    wire grant_s = pins_s[4];
    wire ready_s = ~pins_s[3];
    wire strb_s  = pins_s[2];
    wire iack_s  = pins_s[1];
    wire as_s    = pins_s[0];
    wire strb_rise = strb_s & ~pin_prev_q[2];
    wire strb_fall = ~strb_s & pin_prev_q[2];
    wire iack_rise = iack_s & ~pin_prev_q[1];
    wire iack_fall = ~iack_s & pin_prev_q[1];
    wire as_rise   = as_s & ~pin_prev_q[0];

    // dma channel selection; lowest enabled channel is served first
    wire       ch_sel  = ~en_q[0];
    wire       dma_run = (|en_q) && (cnt_q != 16'h0000);
    wire       idle    = st[0];

    sdbm_xfer u_xfer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .start_i   (bus_request_out_o & dma_run),
        .grant_i   (grant_s),
        .ready_i   (ready_s),
        .st_o      (st),
        .done_o    (xfer_done)
    );

    // apb decode
    wire setup  = psel_i & ~penable_i;
    wire access = psel_i & penable_i & pready_o;
    wire wr     = access & pwrite_i;
    wire rd     = access & ~pwrite_i;

    function mapped;
        input [7:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `SDBM_OFF_DMAIRQ);
        end
    endfunction

    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // vector with source encoded in bits 3..1
    function [7:0] vec_of;
        input [7:0] base;
        input [2:0] src;
        begin
            vec_of = {base[7:4], src, base[0]};
        end
    endfunction

    // highest priority pending source
    wire [2:0] src_now = ip_q[0] ? `SDBM_SRC_DMA0 :
                         ip_q[1] ? `SDBM_SRC_DMA1 :
                         ser_q   ? `SDBM_SRC_SERIAL : `SDBM_SRC_NONE;
    wire [7:0] vecb    = mic_q[`SDBM_MIC_SOFTACK] ? vec_of(veca_q, src_now) : veca_q;
    wire       tc_now  = xfer_done && (cnt_q == 16'h0001);
    wire       soft_rd = rd && hit(paddr_i, `SDBM_OFF_VECB) && mic_q[`SDBM_MIC_SOFTACK];
    wire [2:0] gap_min = mic_q[`SDBM_MIC_ALIGNED] ? `SDBM_RECOV_ALIGN : `SDBM_RECOV_OTHER;
    wire       recov_bad = (strb_fall || iack_fall) && gap_arm_q && (gap_q < gap_min);
    wire       ack_take  = iack_fall && !(mic_q[`SDBM_MIC_DBLPULSE] && !ack_first_q);

    // read data captured in setup so the access phase answers at once
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup;
            pslverr_o <= setup & ~mapped(paddr_i);
            prdata_o  <= 32'h00000000;
            if (setup && !pwrite_i) begin
                case (paddr_i)
                    `SDBM_OFF_MIC:    prdata_o <= {24'h000000, mic_q};
                    `SDBM_OFF_DMAEN:  prdata_o <= {30'h00000000, en_q};
                    `SDBM_OFF_TCSTAT: prdata_o <= {30'h00000000, tc_q};
                    `SDBM_OFF_ADDR:   prdata_o <= addr_q;
                    `SDBM_OFF_COUNT:  prdata_o <= {16'h0000, cnt_q};
                    `SDBM_OFF_VECA:   prdata_o <= {24'h000000, veca_q};
                    `SDBM_OFF_VECB:   prdata_o <= {24'h000000, vecb};
                    `SDBM_OFF_ISTAT:  prdata_o <= {28'h0000000, istat_q};
                    `SDBM_OFF_IMASK:  prdata_o <= {28'h0000000, imask_q};
                    `SDBM_OFF_DMAIRQ: prdata_o <= {28'h0000000, ius_q, ip_q};
                    default:          prdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // control registers, address and count
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            mic_q   <= `SDBM_MIC_RST;
            veca_q  <= `SDBM_VEC_RST;
            imask_q <= 4'h0;
            addr_q  <= 32'h00000000;
            cnt_q   <= 16'h0000;
        end else begin
            if (wr && hit(paddr_i, `SDBM_OFF_MIC))
                mic_q <= pwdata_i[7:0];
            if (wr && hit(paddr_i, `SDBM_OFF_VECA))
                veca_q <= pwdata_i[7:0];
            if (wr && hit(paddr_i, `SDBM_OFF_IMASK))
                imask_q <= pwdata_i[3:0];
            if (wr && hit(paddr_i, `SDBM_OFF_ADDR))
                addr_q <= pwdata_i;
            else if (xfer_done)
                addr_q <= addr_q + 32'h00000001;
            if (wr && hit(paddr_i, `SDBM_OFF_COUNT))
                cnt_q <= pwdata_i[15:0];
            else if (xfer_done)
                cnt_q <= cnt_q - 16'h0001;
        end
    end

    // channel enables: command code or enable register both start dma
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            en_q <= 2'b00;
        end else begin
            if (wr && hit(paddr_i, `SDBM_OFF_DMAEN))
                en_q <= pwdata_i[1:0];
            else if (wr && hit(paddr_i, `SDBM_OFF_CMD) &&
                     pwdata_i[`SDBM_CMD_HI:`SDBM_CMD_LO] == `SDBM_CMD_ENB_TXB)
                en_q[`SDBM_CH_TXB] <= 1'b1;
            else if (tc_now)
                en_q[ch_sel] <= 1'b0;
        end
    end

    // terminal count: set wins over the clear on read
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            tc_q <= 2'b00;
        end else begin
            if (rd && hit(paddr_i, `SDBM_OFF_TCSTAT))
                tc_q <= 2'b00;
            if (tc_now)
                tc_q[ch_sel] <= 1'b1;
        end
    end

    // dma interrupt: pending then under service, no software ack path
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ip_q  <= 2'b00;
            ius_q <= 2'b00;
        end else begin
            if (wr && hit(paddr_i, `SDBM_OFF_DMAIRQ))
                ius_q <= ius_q & ~pwdata_i[3:2];
            if (ack_take && src_now == `SDBM_SRC_DMA0) begin
                ip_q[0]  <= 1'b0;
                ius_q[0] <= 1'b1;
            end else if (ack_take && src_now == `SDBM_SRC_DMA1) begin
                ip_q[1]  <= 1'b0;
                ius_q[1] <= 1'b1;
            end
            if (tc_now)
                ip_q[ch_sel] <= 1'b1;
        end
    end

    // serial status: in mux mode it is refreshed only by an address strobe
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ser_q            <= 1'b0;
            serial_irq_clr_o <= 1'b0;
        end else begin
            serial_irq_clr_o <= soft_rd;
            if (soft_rd && src_now == `SDBM_SRC_SERIAL)
                ser_q <= 1'b0;
            else if (!mic_q[`SDBM_MIC_MUX] || as_rise)
                ser_q <= serial_irq_i;
        end
    end

    // strobe recovery check, counted on every access and acknowledge strobe without chip select
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            pin_prev_q <= 5'h0F;
            gap_q      <= 3'h0;
            gap_arm_q  <= 1'b0;
        end else begin
            pin_prev_q <= pins_s;
            if (strb_rise || iack_rise) begin
                gap_q     <= 3'h0;
                gap_arm_q <= 1'b1;
            end else if (strb_fall || iack_fall) begin
                gap_arm_q <= 1'b0;
            end else if (gap_q != 3'h7) begin
                gap_q <= gap_q + 3'h1;
            end
        end
    end

    // sticky status, write one to clear; a new event beats the clear
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            istat_q <= 4'h0;
            irq_o   <= 1'b0;
        end else begin
            istat_q <= (wr && hit(paddr_i, `SDBM_OFF_ISTAT)) ?
                       (istat_q & ~pwdata_i[3:0]) : istat_q;
            if (tc_now && !ch_sel)
                istat_q[`SDBM_EV_TC0] <= 1'b1;
            if (tc_now && ch_sel)
                istat_q[`SDBM_EV_TC1] <= 1'b1;
            if (recov_bad)
                istat_q[`SDBM_EV_RECOV] <= 1'b1;
            if (ser_q)
                istat_q[`SDBM_EV_SERIAL] <= 1'b1;
            irq_o <= |(istat_q & imask_q);
        end
    end

    // acknowledge: double pulse mode skips the first pulse
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ack_first_q <= 1'b0;
            vec_drive_q <= 1'b0;
            vec_q       <= 8'h00;
        end else begin
            if (iack_fall && mic_q[`SDBM_MIC_DBLPULSE] && !ack_first_q) begin
                ack_first_q <= 1'b1;
            end else if (ack_take) begin
                ack_first_q <= 1'b0;
                vec_drive_q <= 1'b1;
                vec_q       <= vec_of(veca_q, src_now);
            end
            if (iack_rise)
                vec_drive_q <= 1'b0;
        end
    end

    // request held while work remains; dropped once the count runs out
    always @(posedge sys_clk_i) begin
        if (rst_i)
            bus_request_out_o <= 1'b0;
        else
            bus_request_out_o <= dma_run && !tc_now;
    end

    // master outputs; address phases drive only when granted, vector is driven without grant on both halves
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            ad_o                  <= 16'h0000;
            ad_oe_o               <= 1'b0;
            upper_addr_strobe_o   <= 1'b0;
            addr_latch_strobe_n_o <= 1'b1;
            data_strobe_n_o       <= 1'b1;
            read_not_write_o      <= 1'b1;
            master_oe_o           <= 1'b0;
            tx_data_o             <= 8'h00;
            tx_valid_o            <= 1'b0;
        end else begin
            master_oe_o           <= grant_s && !idle;
            upper_addr_strobe_o   <= grant_s && st[1];
            addr_latch_strobe_n_o <= !(grant_s && st[2]);
            data_strobe_n_o       <= !(grant_s && (st[4] | st[5] | st[6]));
            read_not_write_o      <= 1'b1;
            tx_valid_o            <= 1'b0;
            if (grant_s && st[1]) begin
                ad_o    <= addr_q[31:16];
                ad_oe_o <= 1'b1;
            end else if (grant_s && st[2]) begin
                ad_o    <= addr_q[15:0];
                ad_oe_o <= 1'b1;
            end else if (vec_drive_q && !master_oe_o) begin
                ad_o    <= {vec_q, vec_q};
                ad_oe_o <= 1'b1;
            end else begin
                ad_oe_o <= 1'b0;
            end
            // memory data is sampled once ready has let t3 pass
            if (st[7]) begin
                tx_data_o  <= ad_i[7:0];
                tx_valid_o <= 1'b1;
            end
        end
    end
endmodule

/* File: logic/sdbm_xfer.v */
// dma master cycle sequencer: two setup states then six transfer states
`timescale 1ns/10ps
module sdbm_xfer (
    input  wire       sys_clk_i,
    input  wire       rst_i,
    // control
    input  wire       start_i,
    input  wire       grant_i,
    input  wire       ready_i,
    // state and completion
    output reg  [8:0] st_o,
    output reg        done_o
);
    localparam S_IDLE = 9'h001;
    localparam S_TS0  = 9'h002;
    localparam S_TS1  = 9'h004;
    localparam S_T0   = 9'h008;
    localparam S_T1   = 9'h010;
    localparam S_T2   = 9'h020;
    localparam S_T3   = 9'h040;
    localparam S_T4   = 9'h080;
    localparam S_T5   = 9'h100;

    // one state per clock; only T3 stretches for the ready input
    // no restart in the done cycle: count and request are still stale then
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            st_o   <= S_IDLE;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (st_o)
                S_IDLE: if (start_i && grant_i && !done_o) st_o <= S_TS0;
                S_TS0:  st_o <= S_TS1; // upper strobe phase always taken
                S_TS1:  st_o <= S_T0;
                S_T0:   st_o <= S_T1;
                S_T1:   st_o <= S_T2;
                S_T2:   st_o <= S_T3;
                S_T3:   if (ready_i) st_o <= S_T4;
                S_T4:   st_o <= S_T5;
                S_T5: begin
                    st_o   <= S_IDLE;
                    done_o <= 1'b1;
                end
                default: st_o <= S_IDLE;
            endcase
        end
    end
endmodule
